/* File: dv/crc_wb_master.sv */
// Wishbone classic master that stands in for the processor side of the checksum unit.
// Assumes one rising-edge clock shared with the slave; the bench calls xfer for each access.
`timescale 1ns/1ps

module crc_wb_master (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o = 1'b0,
	output logic stb_o = 1'b0,
	output logic we_o = 1'b0,
	output logic [7:0] adr_o = 8'h00,
	output logic [3:0] sel_o = 4'h0,
	output logic [31:0] dat_o = 32'h00000000
);

	// ************************************************
	// Single request, held until ack is sampled high
	// ************************************************
	// The caller picks the width; sel other than f goes to the data port and to one refused polynomial write
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] q, output int n);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= s;
		dat_o <= d;
		n = 0;
		// Edges waited; 2 means no wait state
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 64);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		dat_o <= ~d; // Released data no longer shows the old value
	endtask

endmodule

/* File: dv/test_programmable_crc_unit.sv */
// Self-checking bench for the programmable checksum unit.
// Assumes the Wishbone master model drives every bus input of the unit.
`timescale 1ns/1ps

module test_programmable_crc_unit;

	typedef struct packed {logic [7:0] ctl; logic [31:0] poly; logic [31:0] init; logic [31:0] dat; logic [3:0] sel;} row_t;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rd, c;
	int nw, n1, n2, w, nb, g;
	int miscompares = 0;
	int n_checks = 0;
	// Odd polynomials only, one row per size, reversal and width
	row_t rows[10] = '{
		'{8'h00, 32'h04c11db7, 32'hffffffff, 32'h1a2b3c4d, 4'hf},
		'{8'h08, 32'h00008005, 32'hffffffff, 32'h00001234, 4'h3},
		'{8'h10, 32'h00000007, 32'h00000000, 32'h000000a5, 4'h1},
		'{8'h18, 32'h00000009, 32'h0000007f, 32'h0000005a, 4'h1},
		'{8'h20, 32'h04c11db7, 32'hffffffff, 32'h1a2b3c4d, 4'hf},
		'{8'h40, 32'h04c11db7, 32'h00000000, 32'h1a2b3c4d, 4'hf},
		'{8'he0, 32'h04c11db7, 32'hffffffff, 32'h1a2b3c4d, 4'hf},
		'{8'h88, 32'h00008005, 32'h0000ffff, 32'h0000beef, 4'h3},
		'{8'h40, 32'h04c11db7, 32'hffffffff, 32'h1a2b3c4d, 4'h1},
		'{8'h68, 32'h00008005, 32'hffffffff, 32'h1a2bbeef, 4'h3}};

	always #50 clk_i = ~clk_i;

	programmable_crc_unit programmable_crc_unit_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack));

	crc_wb_master crc_wb_master_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

	// ************************************************
	// Reference model and checking tasks
	// ************************************************
	// Reverse the bit order inside groups of g bits
	function automatic logic [31:0] rev(logic [31:0] v, int g);
		logic [31:0] r;
		for (int i = 0; i < 32; i++) r[i] = v[(i / g) * g + g - 1 - i % g];
		return r;
	endfunction

	// MSB-first checksum update over nb right-aligned bytes, w-bit polynomial
	function automatic logic [31:0] step(logic [31:0] c0, logic [31:0] d, int nb, logic [31:0] p, int w);
		logic [31:0] m;
		logic fb;
		m = (w == 32) ? 32'hffffffff : (32'h1 << w) - 1;
		for (int i = nb * 8 - 1; i >= 0; i--) begin
			fb = c0[w - 1] ^ d[i];
			c0 = (c0 << 1) & m;
			if (fb) c0 = c0 ^ (p & m);
		end
		return c0 & m;
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		crc_wb_master_inst.xfer(w, a, s, d, rd, nw);
		if (nw >= 64) begin
			$display("unexpected at %0t: no acknowledge", $time);
			miscompares++;
			stop_test();
		end
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: read %h, want %h", $time, got, exp);
			miscompares++;
		end
	endtask

	task automatic chk_wait(input int got, input int exp);
		n_checks++;
		if (got != exp) begin
			$display("unexpected at %0t: waited %0d edges, want %0d", $time, got, exp);
			miscompares++;
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 4'hf, 32'h0);
		chk_word(rd, exp);
	endtask

	// ************************************************
	// Main sequence
	// ************************************************
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values of every register
		rdchk(8'h00, 32'hffffffff);
		rdchk(8'h04, 32'h0);
		rdchk(8'h08, 32'h0);
		rdchk(8'h10, 32'hffffffff);
		rdchk(8'h14, 32'h04c11db7);
		$display("test reset_values done");
		// Table: polynomial, control, init (which restarts), one data write, read back
		foreach (rows[i]) begin
			bus(1'b1, 8'h14, 4'hf, rows[i].poly);
			bus(1'b1, 8'h08, 4'hf, {24'h0, rows[i].ctl});
			bus(1'b1, 8'h10, 4'hf, rows[i].init);
			bus(1'b1, 8'h00, rows[i].sel, rows[i].dat);
			w = rows[i].ctl[4:3] == 2'b00 ? 32 : rows[i].ctl[4:3] == 2'b01 ? 16 : rows[i].ctl[4:3] == 2'b10 ? 8 : 7;
			nb = rows[i].sel == 4'hf ? 4 : rows[i].sel == 4'h3 ? 2 : 1;
			g = rows[i].ctl[6:5] == 2'b01 ? 8 : rows[i].ctl[6:5] == 2'b10 ? 16 : 32;
			// A reversal group wider than the write is cut down to its width
			if (g > nb * 8) g = nb * 8;
			c = rows[i].ctl[6:5] == 2'b00 ? rows[i].dat : rev(rows[i].dat, g);
			c = step(rows[i].init, c, nb, rows[i].poly, w);
			if (rows[i].ctl[7]) c = rev(c, 32);
			rdchk(8'h00, c);
		end
		$display("test table done");
		// Word then byte back to back, read at once: five bytes in one run
		bus(1'b1, 8'h14, 4'hf, 32'h04c11db7);
		bus(1'b1, 8'h08, 4'hf, 32'h1);
		bus(1'b1, 8'h00, 4'hf, 32'hdeadbeef);
		n1 = nw;
		bus(1'b1, 8'h00, 4'h1, 32'h00000042);
		n2 = nw;
		chk_wait(n1, 2);
		chk_wait(n2, 2);
		rdchk(8'h00, step(step(rows[9].init, 32'hdeadbeef, 4, 32'h04c11db7, 32),
			32'h42, 1, 32'h04c11db7, 32));
		$display("test back_to_back done");
		// Init write, scratch byte, then the reset control bit
		bus(1'b1, 8'h10, 4'hf, 32'h12345678);
		rdchk(8'h00, 32'h12345678);
		bus(1'b1, 8'h04, 4'hf, 32'h0000005a);
		bus(1'b1, 8'h00, 4'h1, 32'h00000011);
		bus(1'b1, 8'h08, 4'hf, 32'h1);
		rdchk(8'h04, 32'h5a);
		rdchk(8'h08, 32'h0);
		rdchk(8'h00, 32'h12345678);
		$display("test init_and_reset_bit done");
		// Refused widths and an unmapped place
		bus(1'b1, 8'h14, 4'h3, 32'h00000007);
		rdchk(8'h14, 32'h04c11db7);
		bus(1'b1, 8'h00, 4'h2, 32'h0000ff00);
		rdchk(8'h00, 32'h12345678);
		rdchk(8'h0c, 32'h0);
		$display("test refusals done");
		// Second reset in mid-run restores the polynomial
		bus(1'b1, 8'h14, 4'hf, 32'h00000007);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk(8'h14, 32'h04c11db7);
		$display("test second_reset done");
		stop_test();
	end

endmodule

/* File: rtl/crc_cfg.svh */
// Offsets, field positions, reset values and timing counts of the checksum unit.
// Assumes a Wishbone slave decoding byte addresses with 32-bit aligned registers.
`ifndef CRC_CFG_SVH
`define CRC_CFG_SVH

// ************************************************
// Register offsets (byte addresses)
// ************************************************
`define CRC_OFS_DATA 8'h00
`define CRC_OFS_SCRATCH 8'h04
`define CRC_OFS_CTRL 8'h08
`define CRC_OFS_INIT 8'h10
`define CRC_OFS_POLY 8'h14

// ************************************************
// Control fields
// ************************************************
`define CRC_CTL_RESET 0
`define CRC_CTL_SIZE_LO 3
`define CRC_CTL_REVIN_LO 5
`define CRC_CTL_REVOUT 7

// ************************************************
// Reset values
// ************************************************
`define CRC_RST_DATA 32'hffffffff
`define CRC_RST_INIT 32'hffffffff
`define CRC_RST_POLY 32'h04c11db7
`define CRC_RST_SCRATCH 8'h00

// ************************************************
// Byte-lane selects and cycle counts per width
// ************************************************
`define CRC_SEL_WORD 4'hf
`define CRC_SEL_HALF 4'h3
`define CRC_SEL_BYTE 4'h1
`define CRC_CYC_WORD 3'h4
`define CRC_CYC_HALF 3'h2
`define CRC_CYC_BYTE 3'h1

`endif

/* File: rtl/crc_pkg.sv */
// Types shared by the checksum unit.
// Assumes field codes match the control register encoding.
package crc_pkg;

	// Polynomial width choice, codes in declaration order 00..11
	typedef enum logic [1:0] {SZ32, SZ16, SZ8, SZ7} poly_size_t;

	// Input reversal choice, codes in declaration order 00..11
	typedef enum logic [1:0] {REV_NONE, REV_BYTE, REV_HALF, REV_WORD} rev_mode_t;

	// One data write waiting for the engine, top-aligned bytes
	typedef struct packed {
		logic [31:0] data;
		logic [2:0] nbytes;
	} job_t;

	// Control register contents
	typedef struct packed {
		logic output_bit_reverse;
		rev_mode_t input_bit_reverse;
		poly_size_t size;
	} ctrl_t;

endpackage

/* File: rtl/programmable_crc_unit.sv */
// Programmable checksum unit with a classic Wishbone register slave.
// Assumes a single clock, synchronous active-high reset, held master requests.
`timescale 1ns/1ps
`include "crc_cfg.svh"

module programmable_crc_unit import crc_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o
);

	// ************************************************
	// Helper functions
	// ************************************************

	// Valid-bit mask for the chosen polynomial width
	function automatic logic [31:0] size_mask(input poly_size_t sz);
		case (sz)
			SZ32: size_mask = 32'hffffffff;
			SZ16: size_mask = 32'h0000ffff;
			SZ8: size_mask = 32'h000000ff;
			default: size_mask = 32'h0000007f;
		endcase
	endfunction

	// Fold one byte, MSB first, into a checksum of the chosen width
	function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] d,
			input logic [31:0] poly, input poly_size_t sz);
		logic [31:0] c;
		logic [31:0] m;
		logic [31:0] top;
		logic fb;
		c = crc;
		m = size_mask(sz);
		top = m ^ (m >> 1);
		for (int i = 7; i >= 0; i--) begin
			fb = (|(c & top)) ^ d[i];
			c = (c << 1) & m;
			if (fb) begin
				c = c ^ (poly & m);
			end
		end
		crc_byte = c;
	endfunction

	// Reverse bit order inside each group of the given number of bytes
	function automatic logic [31:0] rev_groups(input logic [31:0] x, input int gb);
		logic [31:0] r;
		r = 32'h00000000;
		for (int b = 0; b < 32; b++) begin
			r[(b / (gb * 8)) * gb * 8 + (gb * 8 - 1 - (b % (gb * 8)))] = x[b];
		end
		rev_groups = r;
	endfunction

	// Turn a data-port write into a top-aligned job
	function automatic job_t prep_job(input logic [31:0] d, input logic [3:0] sel, input rev_mode_t rm);
		job_t j;
		logic [31:0] r;
		case (rm)
			REV_BYTE: r = rev_groups(d, 1);
			REV_HALF: r = (sel == `CRC_SEL_WORD) ? rev_groups(d, 2) :
				(sel == `CRC_SEL_HALF) ? rev_groups(d, 2) : rev_groups(d, 1);
			REV_WORD: r = (sel == `CRC_SEL_WORD) ? rev_groups(d, 4) :
				(sel == `CRC_SEL_HALF) ? rev_groups(d, 2) : rev_groups(d, 1);
			default: r = d;
		endcase
		if (sel == `CRC_SEL_WORD) begin
			j.data = r;
			j.nbytes = `CRC_CYC_WORD;
		end else if (sel == `CRC_SEL_HALF) begin
			j.data = {r[15:0], 16'h0000};
			j.nbytes = `CRC_CYC_HALF;
		end else begin
			j.data = {r[7:0], 24'h000000};
			j.nbytes = `CRC_CYC_BYTE;
		end
		prep_job = j;
	endfunction

	// ************************************************
	// State
	// ************************************************
	logic [31:0] crc_q, crc_d;
	logic [31:0] init_q, init_d;
	logic [31:0] poly_q, poly_d;
	logic [7:0] scratch_q, scratch_d;
	ctrl_t ctrl_q, ctrl_d;
	logic [31:0] sh_q, sh_d;
	logic [2:0] cnt_q, cnt_d;
	job_t buf_q, buf_d;
	logic buf_v_q, buf_v_d;
	logic ack_q, ack_d;
	logic [31:0] dat_q, dat_d;

	logic req;
	logic [7:0] ofs;
	logic sel_ok;
	logic full_word;
	logic idle;
	logic [31:0] crc_out;

	// Request decode and read-back value
	assign req = cyc_i & stb_i & ~ack_q;
	assign ofs = {adr_i[7:2], 2'b00};
	assign sel_ok = (sel_i == `CRC_SEL_WORD) || (sel_i == `CRC_SEL_HALF) || (sel_i == `CRC_SEL_BYTE);
	assign full_word = (sel_i == `CRC_SEL_WORD);
	assign idle = (cnt_q == 3'h0) && !buf_v_q;
	assign crc_out = ctrl_q.output_bit_reverse ? rev_groups(crc_q & size_mask(ctrl_q.size), 4) :
		(crc_q & size_mask(ctrl_q.size));

	// ************************************************
	// Next-state logic: engine, buffer and bus slave
	// ************************************************
	always_comb begin
		crc_d = crc_q;
		init_d = init_q;
		poly_d = poly_q;
		scratch_d = scratch_q;
		ctrl_d = ctrl_q;
		sh_d = sh_q;
		cnt_d = cnt_q;
		buf_d = buf_q;
		buf_v_d = buf_v_q;
		ack_d = 1'b0;
		dat_d = dat_q;
		// One byte per cycle through the engine
		if (cnt_q != 3'h0) begin
			crc_d = crc_byte(crc_q, sh_q[31:24], poly_q, ctrl_q.size);
			sh_d = sh_q << 8;
			cnt_d = cnt_q - 3'h1;
		end
		// Buffered write moves in as the engine finishes
		if ((cnt_q <= 3'h1) && buf_v_q) begin
			sh_d = buf_q.data;
			cnt_d = buf_q.nbytes;
			buf_v_d = 1'b0;
		end
		if (req) begin
			case (ofs)
				`CRC_OFS_DATA: begin
					if (we_i) begin
						if (!sel_ok) begin
							ack_d = 1'b1;
						end else if (cnt_q == 3'h0 && !buf_v_q) begin
							{sh_d, cnt_d} = prep_job(dat_i, sel_i, ctrl_q.input_bit_reverse);
							ack_d = 1'b1;
						end else if (!buf_v_q) begin
							buf_d = prep_job(dat_i, sel_i, ctrl_q.input_bit_reverse);
							buf_v_d = 1'b1;
							ack_d = 1'b1;
						end
					end else if (idle) begin
						dat_d = crc_out;
						ack_d = 1'b1;
					end
				end
				`CRC_OFS_SCRATCH: begin
					if (we_i && full_word) begin
						scratch_d = dat_i[7:0];
					end
					dat_d = {24'h000000, scratch_q};
					ack_d = 1'b1;
				end
				`CRC_OFS_CTRL: begin
					if (we_i && full_word) begin
						ctrl_d.output_bit_reverse = dat_i[`CRC_CTL_REVOUT];
						ctrl_d.input_bit_reverse = rev_mode_t'(dat_i[`CRC_CTL_REVIN_LO +: 2]);
						ctrl_d.size = poly_size_t'(dat_i[`CRC_CTL_SIZE_LO +: 2]);
						if (dat_i[`CRC_CTL_RESET]) begin
							crc_d = init_q;
							cnt_d = 3'h0;
							buf_v_d = 1'b0;
						end
					end
					// Reset bit is never stored, so it reads back cleared
					dat_d = {24'h000000, ctrl_q.output_bit_reverse, ctrl_q.input_bit_reverse, ctrl_q.size, 3'b000};
					ack_d = 1'b1;
				end
				`CRC_OFS_INIT: begin
					if (we_i && full_word) begin
						init_d = dat_i;
						crc_d = dat_i;
						cnt_d = 3'h0;
						buf_v_d = 1'b0;
					end
					dat_d = init_q;
					ack_d = 1'b1;
				end
				`CRC_OFS_POLY: begin
					if (we_i && full_word) begin
						poly_d = dat_i;
					end
					dat_d = poly_q;
					ack_d = 1'b1;
				end
				default: begin
					dat_d = 32'h00000000;
					ack_d = 1'b1;
				end
			endcase
		end
	end

	// Register everything
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			crc_q <= `CRC_RST_DATA;
			init_q <= `CRC_RST_INIT;
			poly_q <= `CRC_RST_POLY;
			scratch_q <= `CRC_RST_SCRATCH;
			ctrl_q <= '0;
			sh_q <= 32'h00000000;
			cnt_q <= 3'h0;
			buf_q <= '0;
			buf_v_q <= 1'b0;
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			crc_q <= crc_d;
			init_q <= init_d;
			poly_q <= poly_d;
			scratch_q <= scratch_d;
			ctrl_q <= ctrl_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			buf_q <= buf_d;
			buf_v_q <= buf_v_d;
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// ************************************************
	// Assertions and covers
	// ************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic ack_data_wr, ack_data_rd, ack_ctrl_wr;
	assign ack_data_wr = ack_q && we_i && (ofs == `CRC_OFS_DATA);
	assign ack_data_rd = ack_q && !we_i && (ofs == `CRC_OFS_DATA);
	assign ack_ctrl_wr = ack_q && we_i && (ofs == `CRC_OFS_CTRL) && full_word;

	word_time_a: assert property (ack_data_wr && full_word && $past(idle) |-> cnt_q == 3'h4 ##3 cnt_q == 3'h1)
		else $error("word update not four cycles");
	half_time_a: assert property (ack_data_wr && sel_i == `CRC_SEL_HALF && $past(idle) |-> cnt_q == 3'h2 ##1 cnt_q == 3'h1)
		else $error("half-word update not two cycles");
	byte_time_a: assert property (ack_data_wr && sel_i == `CRC_SEL_BYTE && $past(idle) |-> cnt_q == 3'h1 ##1 cnt_q == 3'h0)
		else $error("byte update not one cycle");
	buffer_nowait_a: assert property (req && we_i && ofs == `CRC_OFS_DATA && sel_ok && !buf_v_q |=> ack_q)
		else $error("buffered write waited");
	read_fresh_a: assert property (ack_data_rd |-> $past(cnt_q) == 3'h0 && !$past(buf_v_q))
		else $error("read returned while update pending");
	reset_load_a: assert property (ack_ctrl_wr && dat_i[0] |-> crc_q == init_q && cnt_q == 3'h0 && !buf_v_q)
		else $error("reset bit did not load initial value");
	reset_clear_a: assert property (ack_q && !we_i && ofs == `CRC_OFS_CTRL |-> dat_o[0] == 1'b0)
		else $error("reset bit reads set");
	scratch_keep_a: assert property (ack_ctrl_wr |-> $stable(scratch_q))
		else $error("scratch changed by control write");
	init_load_a: assert property (ack_q && we_i && ofs == `CRC_OFS_INIT && full_word |-> crc_q == dat_i)
		else $error("initial value write did not load checksum");
	poly_reset_a: assert property ($fell(rst_i) |-> poly_q == `CRC_RST_POLY)
		else $error("polynomial reset value wrong");
	narrow_out_a: assert property (ack_data_rd && !ctrl_q.output_bit_reverse && ctrl_q.size == SZ16 |-> dat_o[31:16] == 16'h0000)
		else $error("narrow checksum not in low bits");

	// Buffer hand-over, read stall and register-side guards
	buffer_drain_a: assert property (buf_v_q && cnt_q <= 3'h1 |=> !buf_v_q)
		else $error("buffered write not taken by engine");
	read_wait_a: assert property (req && !we_i && ofs == `CRC_OFS_DATA && !idle |=> !ack_q)
		else $error("read acknowledged while update pending");
	plain_read_a: assert property (ack_data_rd && !ctrl_q.output_bit_reverse && ctrl_q.size == SZ32
		|-> dat_o == crc_q) else $error("data read differs from checksum");
	width_refuse_a: assert property (ack_q && we_i && ofs == `CRC_OFS_POLY && !full_word
		|-> $stable(poly_q)) else $error("narrow polynomial write took effect");
	init_keep_a: assert property (ack_ctrl_wr |-> $stable(init_q))
		else $error("control write changed initial value");
	scratch_write_a: assert property (ack_q && we_i && ofs == `CRC_OFS_SCRATCH && full_word
		|-> scratch_q == dat_i[7:0]) else $error("scratch write lost");
	cnt_bound_a: assert property (cnt_q <= 3'h4)
		else $error("byte counter out of range");
	poly_hold_a: assert property (!(ack_q && we_i && ofs == `CRC_OFS_POLY) |-> $stable(poly_q))
		else $error("polynomial changed without a write");

	mixed_run_c: cover property (ack_data_wr && full_word ##[2:6] ack_data_wr && sel_i == `CRC_SEL_BYTE);
	buffered_c: cover property (buf_v_q && cnt_q != 3'h0);
	read_stall_c: cover property (req && !we_i && ofs == `CRC_OFS_DATA && !idle);
	rev_read_c: cover property (ack_data_rd && ctrl_q.output_bit_reverse);
	half_write_c: cover property (ack_data_wr && sel_i == `CRC_SEL_HALF);

endmodule
